/* dv/rsc_pin_partner.sv */
// External reset source on the reset pin, with the pin's pull-down.
// Assumes go_in is a one-cycle request made at a rising edge.
`timescale 1ns/1ps
module rsc_pin_partner (
    input  wire logic       clk_in,
    input  wire logic       go_in,
    input  wire logic [7:0] hold_in,
    input  wire logic       dev_out_in,
    input  wire logic       dev_oe_in,
    output wire logic       pin_out,
    output wire logic       busy_out
);
    logic [7:0] cnt_r = 8'h00;
    // Hold the pin high for the requested cycles; short holds test refusal
    always @(posedge clk_in) begin
        if (go_in && cnt_r == 8'h00) cnt_r <= hold_in;
        else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
    end
    assign busy_out = (cnt_r != 8'h00);
    // Wired-or with pull-down: idle pin reads low when nobody drives
    assign pin_out = (dev_oe_in & dev_out_in) | busy_out;
endmodule // rsc_pin_partner

/* dv/rsc_reset_ctrl_properties.sv */
// Port checker for the reset source controller.
// Assumes binding to rsc_reset_ctrl with the same warmup parameter.
`timescale 1ns/1ps
`include "rsc_defines.vh"
module rsc_reset_ctrl_properties #(
    parameter WARMUP_CYC = `RSC_WARMUP_CYC
) (
    input wire        REF_CLK_IN,
    input wire        RESET_N_IN,
    input wire        POWER_GOOD_IN,
    input wire        WDT_EXPIRE_IN,
    input wire        OSC_SLOW_IN,
    input wire        STOP_MODE_IN,
    input wire        RST_PIN_IN,
    input wire        RST_PIN_OUT,
    input wire        RST_PIN_OE_OUT,
    input wire        CORE_RESET_OUT,
    input wire        OSC_RUN_OUT,
    input wire        RING_CLK_SEL_OUT,
    input wire [15:0] PC_LOAD_OUT,
    input wire        PC_LOAD_EN_OUT
);
    // ****
    // Helper: good-supply cycles, saturating so warmup can be bounded below
    // ****
    int up_r;
    always @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) up_r <= 0;
        else if (!POWER_GOOD_IN) up_r <= 0;
        else if (up_r < WARMUP_CYC) up_r <= up_r + 1;
    end

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    // Multi-step behaviours
    sequence wdt_hit; WDT_EXPIRE_IN && !CORE_RESET_OUT; endsequence
    sequence int_hold; (CORE_RESET_OUT && RST_PIN_OE_OUT) [*8]; endsequence
    sequence pin_drop;
        $fell(RST_PIN_IN) && CORE_RESET_OUT && !RST_PIN_OE_OUT && !STOP_MODE_IN
            && !OSC_SLOW_IN && up_r == WARMUP_CYC;
    endsequence

    vector_zero_a: assert property (PC_LOAD_EN_OUT |-> PC_LOAD_OUT == 16'h0000)
        else $error("vector load not at zero");
    exit_load_a: assert property ($fell(CORE_RESET_OUT) |-> ##[0:1] PC_LOAD_EN_OUT)
        else $error("no vector load after reset exit");
    osc_kept_a: assert property (CORE_RESET_OUT |-> OSC_RUN_OUT)
        else $error("oscillator off during reset");
    warmup_hold_a: assert property (up_r < WARMUP_CYC |-> CORE_RESET_OUT)
        else $error("core released before warmup");
    power_low_a: assert property (!POWER_GOOD_IN [*3] |-> CORE_RESET_OUT)
        else $error("core running on low supply");
    wdt_reset_a: assert property (wdt_hit |-> ##[1:3] int_hold)
        else $error("watchdog reset missing or short");
    ring_in_reset_a: assert property (RING_CLK_SEL_OUT |-> CORE_RESET_OUT)
        else $error("ring select outside reset");
    stop_no_fail_a: assert property (STOP_MODE_IN && !CORE_RESET_OUT |=> !RING_CLK_SEL_OUT)
        else $error("osc fail reset in stop mode");
    ext_exit_a: assert property (pin_drop |-> ##[1:4] !CORE_RESET_OUT)
        else $error("slow exit after pin release");
    pin_drive_a: assert property (RST_PIN_OE_OUT |-> RST_PIN_OUT && CORE_RESET_OUT)
        else $error("pin driven without reset");
endmodule // rsc_reset_ctrl_properties

bind rsc_reset_ctrl rsc_reset_ctrl_properties #(.WARMUP_CYC(WARMUP_CYC)) rsc_props_i (
    .REF_CLK_IN(REF_CLK_IN), .RESET_N_IN(RESET_N_IN), .POWER_GOOD_IN(POWER_GOOD_IN),
    .WDT_EXPIRE_IN(WDT_EXPIRE_IN), .OSC_SLOW_IN(OSC_SLOW_IN), .STOP_MODE_IN(STOP_MODE_IN),
    .RST_PIN_IN(RST_PIN_IN), .RST_PIN_OUT(RST_PIN_OUT), .RST_PIN_OE_OUT(RST_PIN_OE_OUT),
    .CORE_RESET_OUT(CORE_RESET_OUT), .OSC_RUN_OUT(OSC_RUN_OUT),
    .RING_CLK_SEL_OUT(RING_CLK_SEL_OUT), .PC_LOAD_OUT(PC_LOAD_OUT),
    .PC_LOAD_EN_OUT(PC_LOAD_EN_OUT));

/* dv/rsc_reset_ctrl_tb.sv */
// Testbench: bus tasks and at least one scenario per reset source.
// Assumes the checker bind and pin partner are compiled alongside.
`timescale 1ns/1ps
`include "rsc_defines.vh"
module rsc_reset_ctrl_tb;
    localparam WU = 64; // Short warmup keeps the run brief
    logic clk, rst_n, pg, wdt, slow, stop, go, cyc, stb, we;
    logic [7:0] adr, hold;
    logic [31:0] wdat, q;
    wire pin, pin_o, pin_oe, core, osc_run, ring, pc_en, irq, ack, busy;
    wire [15:0] pc;
    wire [31:0] rdat;
    int err_total, samples_checked, core_cnt, oe_cnt, ring_cnt, loads, i;

    rsc_reset_ctrl #(.WARMUP_CYC(WU)) rsc_reset_ctrl_i (
        .REF_CLK_IN(clk), .RESET_N_IN(rst_n), .POWER_GOOD_IN(pg), .WDT_EXPIRE_IN(wdt),
        .OSC_SLOW_IN(slow), .STOP_MODE_IN(stop), .RING_CLK_ACTIVE_IN(1'b0),
        .RST_PIN_IN(pin), .RST_PIN_OUT(pin_o), .RST_PIN_OE_OUT(pin_oe),
        .CORE_RESET_OUT(core), .OSC_RUN_OUT(osc_run), .RING_CLK_SEL_OUT(ring),
        .PC_LOAD_OUT(pc), .PC_LOAD_EN_OUT(pc_en), .IRQ_OUT(irq), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));
    rsc_pin_partner rsc_pin_partner_i (.clk_in(clk), .go_in(go), .hold_in(hold),
        .dev_out_in(pin_o), .dev_oe_in(pin_oe), .pin_out(pin), .busy_out(busy));

    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Tallies sampled at rising edges; the main flow reads them at falling edges
    always @(posedge clk) begin
        core_cnt += (core === 1'b1);
        oe_cnt += (pin_oe === 1'b1);
        ring_cnt += (ring === 1'b1);
        if (pc_en === 1'b1) begin
            loads++;
            chk({16'h0000, pc}, 32'h0);
        end
    end

    // Classic cycle: launch after an edge, hold until ack, return at a falling edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(negedge clk);
        chk(n < 20, 1);
    endtask

    task automatic arm;
        core_cnt = 0;
        oe_cnt = 0;
        ring_cnt = 0;
        loads = 0;
    endtask

    task automatic pin_pulse(input logic [7:0] h);
        @(posedge clk) hold <= h;
        go <= 1'b1;
        @(posedge clk) go <= 1'b0;
    endtask

    // Wait out one reset episode, then check its length, pin drive and restart
    task automatic done_chk(input int lo, input int hi, input int drv);
        for (int w = 0; w < 400 && core_cnt == 0; w++) @(negedge clk);
        for (int w = 0; w < 400 && core !== 1'b0; w++) @(negedge clk);
        repeat (2) @(negedge clk);
        chk(core_cnt >= lo && core_cnt <= hi, 1);
        if (drv != 2) chk(oe_cnt, drv ? core_cnt : 0);
        chk(loads, 1);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard, well beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        conclude;
    end

    // ****
    // Main sequence
    // ****
    initial begin
        rst_n = 1'b0;
        {pg, wdt, slow, stop, go, cyc, stb, we} = 8'h80;
        {adr, hold, wdat} = 48'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        arm;
        done_chk(WU, 400, 2);
        wb(0, `RSC_WDCTL_OFF, 0);
        chk(q[6], 1);
        chk(irq, 0);
        wb(1, `RSC_IRQ_MASK_OFF, 1);
        chk(irq, 1);
        wb(1, `RSC_IRQ_STAT_OFF, 1);
        chk(irq, 0);
        wb(1, `RSC_IRQ_MASK_OFF, 0);
        wb(1, `RSC_WDCTL_OFF, 0);
        wb(0, `RSC_WDCTL_OFF, 0);
        chk(q & 32'h44, 0);
        wb(0, 8'h1C, 0);
        chk(q, 0);
        arm;
        @(posedge clk) wdt <= 1'b1;
        @(posedge clk) wdt <= 1'b0;
        done_chk(13, 13, 1);
        wb(1, `RSC_WDCTL_OFF, 32'h44);
        wb(0, `RSC_WDCTL_OFF, 0);
        chk(q & 32'h44, 32'h04);
        wb(1, `RSC_WDCTL_OFF, 0);
        wb(1, `RSC_PWCTL_OFF, 32'h10);
        arm;
        @(posedge clk) slow <= 1'b1;
        repeat (30) @(posedge clk);
        slow <= 1'b0;
        done_chk(25, 45, 1);
        chk(ring_cnt > 0, 1);
        wb(0, `RSC_PWCTL_OFF, 0);
        chk(q & 32'h30, 32'h30);
        wb(1, `RSC_PWCTL_OFF, 32'h10);
        wb(0, `RSC_PWCTL_OFF, 0);
        chk(q & 32'h30, 32'h10);
        arm;
        @(posedge clk) stop <= 1'b1;
        slow <= 1'b1;
        repeat (20) @(negedge clk);
        chk(core_cnt, 0);
        chk(osc_run, 0);
        pin_pulse(3);
        done_chk(WU, 400, 0);
        @(posedge clk) stop <= 1'b0;
        slow <= 1'b0;
        wb(1, `RSC_PWCTL_OFF, 0);
        for (i = 0; i < 2; i++) begin
            arm;
            pin_pulse(20 + 40 * i);
            done_chk(10 + 40 * i, 27 + 40 * i, 0);
        end
        arm;
        pin_pulse(3);
        repeat (20) @(negedge clk);
        chk(core_cnt, 0);
        for (i = 1; i < 3; i++) begin
            wb(1, `RSC_TAKEY_OFF, `RSC_TA_KEY1);
            wb(1, `RSC_TAKEY_OFF, `RSC_TA_KEY2);
            arm;
            wb(1, `RSC_CMD_OFF, i);
            done_chk(13, 13, 1);
        end
        arm;
        wb(1, `RSC_CMD_OFF, `RSC_CMD_SYSRST);
        repeat (20) @(negedge clk);
        chk(core_cnt, 0);
        wb(0, `RSC_WDCTL_OFF, 0);
        chk(q & 32'h44, 0);
        wb(1, `RSC_PWCTL_OFF, 32'h10);
        arm;
        @(posedge clk) pg <= 1'b0;
        repeat (10) @(posedge clk);
        pg <= 1'b1;
        done_chk(WU + 8, 400, 1);
        wb(0, `RSC_WDCTL_OFF, 0);
        chk(q[6], 1);
        wb(0, `RSC_PWCTL_OFF, 0);
        chk(q[4], 0);
        conclude;
    end
endmodule // rsc_reset_ctrl_tb

/* src/rsc_defines.vh */
// Constants for the reset source controller: register offsets, bit positions, delays.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define RSC_WDCTL_OFF      8'h00
`define RSC_PWCTL_OFF      8'h04
`define RSC_CMD_OFF        8'h08
`define RSC_TAKEY_OFF      8'h0C
`define RSC_IRQ_STAT_OFF   8'h10
`define RSC_IRQ_MASK_OFF   8'h14
`define RSC_STAT_OFF       8'h18

// ****************************************************************
// Field positions, command codes, unlock keys and window
// ****************************************************************
`define RSC_POR_BIT        6
`define RSC_WDT_BIT        2
`define RSC_OSC_FAIL_DETECT_ENABLE_BIT       4
`define RSC_OSC_FAIL_FLAG_BIT       5
`define RSC_CMD_SYSRST     4'h1
`define RSC_CMD_BANKSW     4'h2
`define RSC_TA_KEY1        8'hAA
`define RSC_TA_KEY2        8'h55
`define RSC_TA_WINDOW      8'h03

// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define RSC_IRQ_POR        0
`define RSC_IRQ_WDT        1
`define RSC_IRQ_OSC        2
`define RSC_IRQ_EXT        3

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define RSC_RESET_VECTOR   16'h0000
`define RSC_WARMUP_CYC     65536
`define RSC_WDT_HOLD_CYC   13
`define RSC_EXT_MIN_CYC    4
`define RSC_EXT_EXIT_CYC   4
`define RSC_OSC_FAIL_HZ    20000
`define RSC_CLK_HZ         100000000

`endif

/* src/rsc_reset_ctrl.v */
// Reset source controller: merges power, watchdog, oscillator-fail, pin and
// command resets, holds the core, times the release, keeps cause flags.
// Assumes power-good, watchdog expiry, osc-fail, stop and ring clock status
// arrive synchronous to REF_CLK_IN; reset pin input is asynchronous.
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "rsc_defines.vh"

module rsc_reset_ctrl #(
    parameter WARMUP_CYC = `RSC_WARMUP_CYC
) (
    input  wire        REF_CLK_IN,
    input  wire        RESET_N_IN,
    input  wire        POWER_GOOD_IN,
    input  wire        WDT_EXPIRE_IN,
    input  wire        OSC_SLOW_IN,
    input  wire        STOP_MODE_IN,
    input  wire        RING_CLK_ACTIVE_IN,
    input  wire        RST_PIN_IN,
    output reg         RST_PIN_OUT,
    output reg         RST_PIN_OE_OUT,
    output reg         CORE_RESET_OUT,
    output reg         OSC_RUN_OUT,
    output reg         RING_CLK_SEL_OUT,
    output reg  [15:0] PC_LOAD_OUT,
    output reg         PC_LOAD_EN_OUT,
    output reg         IRQ_OUT,
    input  wire        WB_CYC_I,
    input  wire        WB_STB_I,
    input  wire        WB_WE_I,
    input  wire [7:0]  WB_ADR_I,
    input  wire [3:0]  WB_SEL_I,
    input  wire [31:0] WB_DAT_I,
    output reg  [31:0] WB_DAT_O,
    output reg         WB_ACK_O
);

    // ****************************************************************
    // States
    // ****************************************************************
    // Sequencer states:
    // RUN    - core executing, pin released
    // POWER  - supply low, everything held
    // WARMUP - oscillator settling before the first fetch
    // WDT    - fixed watchdog hold
    // OSC    - oscillator too slow, running on the ring clock
    // EXT    - held by the outside party on the pin
    // EXIT   - short tail after the oscillator recovers
    // CMD    - fixed hold after a keyed command
    // Binary codes keep the state register at three flops
    localparam ST_RUN    = 3'h0;
    localparam ST_POWER  = 3'h1;
    localparam ST_WARMUP = 3'h2;
    localparam ST_WDT    = 3'h3;
    localparam ST_OSC    = 3'h4;
    localparam ST_EXT    = 3'h5;
    localparam ST_EXIT   = 3'h6;
    localparam ST_CMD    = 3'h7;

    // Counts are worked out at full width, then cut to the counter width on purpose
    // Limitation: the 17-bit counter caps the warmup at 131072 cycles
    localparam [31:0] WARM_FULL = WARMUP_CYC - 1;
    localparam [31:0] WDT_FULL  = `RSC_WDT_HOLD_CYC - 1;
    localparam [31:0] EXIT_FULL = `RSC_EXT_EXIT_CYC - 2;
    localparam [31:0] EXT_FULL  = `RSC_EXT_MIN_CYC;
    localparam [16:0] WARM_CNT  = WARM_FULL[16:0];
    localparam [16:0] WDT_CNT   = WDT_FULL[16:0];
    localparam [16:0] EXIT_CNT  = EXIT_FULL[16:0];
    localparam [2:0]  EXT_MIN   = EXT_FULL[2:0];

    // ****************************************************************
    // Reset release and pin synchroniser
    // ****************************************************************
    reg        rst_s1_r;
    reg        rst_s2_r;
    wire       rst_n = rst_s2_r;
    reg        pin_s1_r;
    reg        pin_s2_r;
    reg  [2:0] pin_cnt_r;

    // Two-stage release so the rest of the logic leaves reset cleanly
    // Only the assertion is asynchronous; release always lands on a clock edge,
    // so no flop sees reset drop close to its own sampling edge
    always @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // Pin is asynchronous; first stage feeds only the second
    always @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
        end else begin
            pin_s1_r <= RST_PIN_IN;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Count high cycles; ignore our own drive so internal resets do not loop back
    // A short glitch restarts the count, so noise under five cycles is refused
    // Limitation: an outside pulse that overlaps our own drive is not counted
    wire pin_hi = pin_s2_r & ~RST_PIN_OE_OUT;
    always @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n)
            pin_cnt_r <= 3'h0;
        else if (!pin_hi)
            pin_cnt_r <= 3'h0;
        else if (pin_cnt_r != EXT_MIN)
            pin_cnt_r <= pin_cnt_r + 3'h1;
    end
    // Stop mode has no running clock to count with, so any high level counts
    wire ext_req = pin_hi & ((pin_cnt_r == EXT_MIN) | STOP_MODE_IN);

    // ****************************************************************
    // Registers and timed access
    // ****************************************************************
    // Software-visible bits live in flops of their own, so a read never
    // disturbs the reset sequencing
    reg        por_flag_r;
    reg        wdt_flag_r;
    reg        osc_fail_detect_enable_r;
    reg        osc_fail_flag_r;
    reg  [3:0] irq_stat_r;
    reg  [3:0] irq_mask_r;
    reg  [1:0] ta_state_r;
    reg  [7:0] ta_cnt_r;
    reg        cmd_req_r;
    reg  [2:0] state_r;
    reg  [2:0] state_nxt;
    reg [16:0] cnt_r;
    reg [16:0] cnt_nxt;
    reg        wake_r;

    wire acc   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire wr    = acc & WB_WE_I & WB_SEL_I[0];
    wire wr_wd = wr & (WB_ADR_I == `RSC_WDCTL_OFF);
    wire wr_pw = wr & (WB_ADR_I == `RSC_PWCTL_OFF);
    wire wr_cm = wr & (WB_ADR_I == `RSC_CMD_OFF);
    wire wr_ta = wr & (WB_ADR_I == `RSC_TAKEY_OFF);
    wire wr_is = wr & (WB_ADR_I == `RSC_IRQ_STAT_OFF);
    wire wr_im = wr & (WB_ADR_I == `RSC_IRQ_MASK_OFF);

    // Cause events, one cycle at the moment each reset is entered
    // Taken from the next state, so flag and reset start on the same edge
    // and no event is lost to a reset that lasts a single cycle
    wire ev_por = (state_nxt == ST_POWER) & (state_r != ST_POWER);
    wire ev_wdt = (state_nxt == ST_WDT) & (state_r != ST_WDT);
    wire ev_osc = (state_nxt == ST_OSC) & (state_r != ST_OSC);
    // Stop-mode pin wake goes straight to warmup; it is still an external reset
    wire wake_nxt = (state_nxt == ST_WARMUP) & (wake_r | (state_r == ST_RUN));
    wire ev_ext = ((state_nxt == ST_EXT) & (state_r != ST_EXT)) | (wake_nxt & ~wake_r);
    wire pwr_low = ~POWER_GOOD_IN;
    wire ta_open = (ta_state_r == 2'h2);

    // Key sequence opens a short window for one command write
    // Any command write closes the window, so one key pair buys one command
    // and a stray write cannot reuse an old unlock
    always @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ta_state_r <= 2'h0;
            ta_cnt_r   <= 8'h00;
            cmd_req_r  <= 1'b0;
        end else begin
            cmd_req_r <= 1'b0;
            if (wr_cm) begin
                ta_state_r <= 2'h0;
                if (ta_open && (WB_DAT_I[3:0] == `RSC_CMD_SYSRST ||
                                WB_DAT_I[3:0] == `RSC_CMD_BANKSW))
                    cmd_req_r <= 1'b1;
            end else if (wr_ta && WB_DAT_I[7:0] == `RSC_TA_KEY1) begin
                ta_state_r <= 2'h1;
                ta_cnt_r   <= `RSC_TA_WINDOW;
            end else if (wr_ta && ta_state_r == 2'h1 && WB_DAT_I[7:0] == `RSC_TA_KEY2) begin
                ta_state_r <= 2'h2;
                ta_cnt_r   <= `RSC_TA_WINDOW;
            end else if (ta_state_r != 2'h0) begin
                if (ta_cnt_r == 8'h00)
                    ta_state_r <= 2'h0;
                else
                    ta_cnt_r <= ta_cnt_r - 8'h01;
            end
        end
    end

    // Cause flags: hardware set wins over a software clear in the same cycle
    // Zero clears and one keeps, so a read-modify-write of the whole
    // register keeps each flag it read as set but wipes one raised between the read and the write
    always @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            por_flag_r <= 1'b1;
            wdt_flag_r <= 1'b0;
            osc_fail_detect_enable_r     <= 1'b0;
            osc_fail_flag_r     <= 1'b0;
            irq_stat_r <= 4'h1;                        // Power-up is itself a power-on event
            irq_mask_r <= 4'h0;
        end else begin
            if (ev_por)
                por_flag_r <= 1'b1;
            else if (wr_wd && !WB_DAT_I[`RSC_POR_BIT])
                por_flag_r <= 1'b0;
            if (ev_wdt)
                wdt_flag_r <= 1'b1;
            else if (wr_wd && !WB_DAT_I[`RSC_WDT_BIT])
                wdt_flag_r <= 1'b0;
            if (pwr_low)
                osc_fail_detect_enable_r <= 1'b0;
            else if (wr_pw)
                osc_fail_detect_enable_r <= WB_DAT_I[`RSC_OSC_FAIL_DETECT_ENABLE_BIT];
            if (ev_osc)
                osc_fail_flag_r <= 1'b1;
            else if (ev_por || (wr_pw && !WB_DAT_I[`RSC_OSC_FAIL_FLAG_BIT]))
                osc_fail_flag_r <= 1'b0;
            irq_stat_r <= (irq_stat_r & ~({4{wr_is}} & WB_DAT_I[3:0]))
                        | {ev_ext, ev_osc, ev_wdt, ev_por};
            if (wr_im)
                irq_mask_r <= WB_DAT_I[3:0];
        end
    end

    // ****************************************************************
    // Reset sequencer
    // ****************************************************************
    // Priority: power, then oscillator fail, pin, watchdog, command
    // Power and oscillator fail override every state, since neither can be
    // trusted to end on its own; the pin is also taken from the watchdog, oscillator, exit and command holds, the others only from run
    // Hazard: keep the default decrement, or a hold state would never end
    always @* begin
        state_nxt = state_r;
        cnt_nxt   = (cnt_r != 17'h0) ? cnt_r - 17'h1 : 17'h0;
        if (pwr_low) begin
            state_nxt = ST_POWER;
            cnt_nxt   = WARM_CNT;
        end else if (osc_fail_detect_enable_r && OSC_SLOW_IN && !STOP_MODE_IN) begin
            state_nxt = ST_OSC;
            cnt_nxt   = EXIT_CNT;
        end else begin
            case (state_r)
                ST_POWER: begin
                    state_nxt = ST_WARMUP;
                    cnt_nxt   = WARM_CNT;
                end
                ST_WARMUP: begin
                    if (cnt_r == 17'h0)
                        state_nxt = ST_RUN;
                end
                ST_WDT, ST_EXIT, ST_OSC, ST_CMD: begin
                    if (ext_req) begin
                        state_nxt = ST_EXT;
                    end else if (state_r == ST_OSC) begin
                        state_nxt = ST_EXIT;
                        cnt_nxt   = EXIT_CNT;
                    end else if (cnt_r == 17'h0) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_EXT: begin
                    // Straight to run; the synchroniser has used two of the four cycles
                    if (!pin_hi)
                        state_nxt = ST_RUN;
                end
                ST_RUN: begin
                    if (ext_req && STOP_MODE_IN) begin
                        state_nxt = ST_WARMUP;
                        cnt_nxt   = WARM_CNT;
                    end else if (ext_req) begin
                        state_nxt = ST_EXT;
                    end else if (WDT_EXPIRE_IN) begin
                        state_nxt = ST_WDT;
                        cnt_nxt   = WDT_CNT;
                    end else if (cmd_req_r) begin
                        state_nxt = ST_CMD;
                        cnt_nxt   = WDT_CNT;
                    end
                end
                default: state_nxt = ST_POWER;
            endcase
        end
    end
    // State, count and wake marker; a stop-mode wake never passes the power
    // state, so it neither flags power-on nor clears the oscillator-fail flag
    always @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_POWER;
            cnt_r   <= 17'h0;
            wake_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            wake_r  <= wake_nxt;
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    // Outputs follow the next state, so each one settles on the edge that
    // changes state and every output still comes straight from a flop
    // Pin-caused resets, stop-mode wake included, leave the pin to its owner
    wire in_rst  = (state_nxt != ST_RUN);
    wire int_rst = in_rst & (state_nxt != ST_EXT) & ~wake_nxt;
    always @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            CORE_RESET_OUT   <= 1'b1;
            OSC_RUN_OUT      <= 1'b1;
            RING_CLK_SEL_OUT <= 1'b0;
            RST_PIN_OUT      <= 1'b0;
            RST_PIN_OE_OUT   <= 1'b0;
            PC_LOAD_OUT      <= `RSC_RESET_VECTOR;
            PC_LOAD_EN_OUT   <= 1'b0;
            IRQ_OUT          <= 1'b0;
        end else begin
            CORE_RESET_OUT   <= in_rst;
            OSC_RUN_OUT      <= in_rst | ~STOP_MODE_IN;
            RING_CLK_SEL_OUT <= (state_nxt == ST_OSC);
            RST_PIN_OUT      <= int_rst;
            RST_PIN_OE_OUT   <= int_rst;
            PC_LOAD_OUT      <= `RSC_RESET_VECTOR;
            PC_LOAD_EN_OUT   <= CORE_RESET_OUT & ~in_rst;
            IRQ_OUT          <= |((irq_stat_r | {ev_ext, ev_osc, ev_wdt, ev_por}) & irq_mask_r);
        end
    end

    // ****************************************************************
    // Wishbone slave: one wait state, unmapped reads give zero
    // ****************************************************************
    // Ack is masked into the access term, so a strobe held after its ack
    // is not taken twice; the master must drop it for a cycle between
    // accesses, which costs one idle cycle per transfer
    always @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0;
        end else begin
            WB_ACK_O <= acc;
            WB_DAT_O <= 32'h0;
            if (acc && !WB_WE_I) begin
                case (WB_ADR_I)
                    `RSC_WDCTL_OFF:    WB_DAT_O <= {25'h0, por_flag_r, 3'h0, wdt_flag_r, 2'h0};
                    `RSC_PWCTL_OFF:    WB_DAT_O <= {26'h0, osc_fail_flag_r, osc_fail_detect_enable_r, 4'h0};
                    `RSC_CMD_OFF:      WB_DAT_O <= {30'h0, ta_state_r};
                    `RSC_IRQ_STAT_OFF: WB_DAT_O <= {28'h0, irq_stat_r};
                    `RSC_IRQ_MASK_OFF: WB_DAT_O <= {28'h0, irq_mask_r};
                    `RSC_STAT_OFF:     WB_DAT_O <= {27'h0, RING_CLK_ACTIVE_IN, state_r, CORE_RESET_OUT};
                    default:           WB_DAT_O <= 32'h0;
                endcase
            end
        end
    end

endmodule // rsc_reset_ctrl
